/* hdl/evt_buffer.sv */
// two-entry event buffer, valid and ready on both sides
`timescale 1ns/1ps
module evt_buffer
(
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    // filling side
    input  wire logic       i_in_valid,
    input  wire logic [7:0] i_in_data,
    output logic            o_in_ready,
    // draining side
    output logic            o_out_valid,
    output logic [7:0]      o_out_data,
    input  wire logic       i_out_ready
);
    typedef struct packed {
        logic [1:0][7:0] slot;   // slot 0 is the head
        logic [1:0]      count;  // 0 to 2 entries
    } buf_type;

    buf_type buf_reg;
    buf_type buf_next;
    logic    push;
    logic    pop;

    // ready and valid from the count register
    assign o_in_ready  = (buf_reg.count != 2'(hub_pkg::BUF_DEPTH));
    assign o_out_valid = (buf_reg.count != 2'd0);
    assign o_out_data  = buf_reg.slot[0];

    // shift on pop, append on push
    always_comb
    begin
        buf_next = buf_reg;
        push     = i_in_valid && o_in_ready;
        pop      = o_out_valid && i_out_ready;
        if (pop)
        begin
            buf_next.slot[0] = buf_reg.slot[1];
        end
        if (push)
        begin
            // never full on push, so the slot index is legal
            buf_next.slot[buf_reg.count - {1'b0, pop}] = i_in_data;
        end
        buf_next.count = buf_reg.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            buf_reg <= '0;
        end
        else
        begin
            buf_reg <= buf_next;
        end
    end
endmodule : evt_buffer

/* hdl/hub_pkg.sv */
// offsets, fields, reset values and codes of the hub registers
package hub_pkg;
    // host register map, byte addresses
    localparam logic [7:0]  RD_BUF_BASE   = 8'h00;         // parameter read buffer, 16 bytes
    localparam logic [7:0]  WR_BUF_BASE   = 8'h5C;         // parameter write buffer, 8 bytes
    localparam logic [7:0]  WR_BUF_LAST   = 8'h63;
    localparam logic [7:0]  PARAM_SEL     = 8'h64;         // direction bit and parameter number
    localparam logic [7:0]  PARAM_ACK     = 8'h3A;         // echo of the last served selector
    localparam logic [7:0]  PTR_MSB_ADDR  = 8'h94;
    localparam logic [7:0]  PTR_LSB_ADDR  = 8'h95;
    localparam logic [7:0]  BYTE_PORT     = 8'h96;
    localparam logic [7:0]  CRC_B0_ADDR   = 8'h97;
    localparam logic [7:0]  CRC_B3_ADDR   = 8'h9A;
    localparam logic [7:0]  RESTART_ADDR  = 8'h9B;
    localparam logic [7:0]  IRQ_ACK_ADDR  = 8'h9C;         // any write drops the host interrupt unless an interrupt set comes in the same cycle
    // selector fields
    localparam int          SEL_DIR_BIT   = 7;             // 1 write, 0 read
    localparam logic [6:0]  PAR_META_NW   = 7'h01;
    localparam logic [6:0]  PAR_FIFO      = 7'h02;
    localparam logic [6:0]  PAR_BANK0     = 7'h03;
    localparam logic [6:0]  PAR_BANK3     = 7'h06;
    localparam logic [6:0]  PAR_META_WK   = 7'h1D;
    // sensor status byte layout
    localparam int          ST_PENDING    = 0;
    localparam int          ST_NO_ACK     = 1;
    localparam int          ST_ID_BAD     = 2;
    localparam int          ST_TRANSIENT  = 3;
    localparam int          ST_LOST       = 4;
    localparam int          ST_POWER_LSB  = 5;
    typedef enum logic [2:0] {
        PWR_ABSENT, PWR_DOWN, PWR_SUSPEND, PWR_SELFTEST,
        PWR_MOTION_INT, PWR_ONE_SHOT, PWR_LOW_ACTIVE, PWR_ACTIVE
    } power_mode_type;
    // reset values and checksum constants
    localparam logic [15:0] PTR_RESET     = 16'h0000;
    localparam logic [31:0] CRC_PRESET    = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_POLY      = 32'hEDB8_8320;
    localparam logic [63:0] META_RESET    = 64'h0000_0000_0000_0000;
    localparam logic [15:0] WM_RESET      = 16'h0000;
    // sizes
    localparam int          SENSOR_COUNT  = 64;
    localparam int          BUF_DEPTH     = 2;
endpackage : hub_pkg

/* hdl/hub_regs.sv */
// host register bank: patch upload, core restart and system parameter mailbox
`timescale 1ns/1ps
// Notes on behaviour
// - sixteen-bit patch pointer, resets to zero
// - pointer high byte at lower address
// - byte port stores bytes while upload enabled
// - checksum readable as four bytes
// - restart write resets core, self-clears
// - mailbox handshake serialises parameter transfers
// - parameter numbers map to system entries
// - banks 0-1 non-wakeup, 2-3 wakeup, read-only
// - meta control: two-bit fields, four per byte
// - enabled meta event queued, may interrupt
// - nonzero watermark interrupts at fill level
// - watermark above size acts as size
// - zero latency, host awake: interrupt per sample
// - fifo control: four little-endian sixteen-bit fields
// - status byte n of bank b
// - status bits zero to four flag errors
// - status bits five to seven give power
// - selector bit seven direction, six-zero parameter
// - write data staged in eight-byte buffer
// - host asleep: only wakeup events interrupt
module hub_regs
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    // decoded host register accesses
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic [7:0]       o_reg_rdata,
    output logic             o_reg_rvalid,
    // chip-level controls
    input  wire logic        i_upload_en,
    input  wire logic        i_host_asleep_bit,
    output logic             o_core_reset,
    output logic             o_host_irq,
    output logic             o_mbox_busy,
    // meta events from the core
    input  wire logic        i_evt_valid,
    input  wire logic [4:0]  i_evt_index,
    input  wire logic        i_evt_wakeup,
    output logic             o_evt_ready,
    // events placed in the output fifo
    output logic             o_fifo_valid,
    output logic [7:0]       o_fifo_data,
    input  wire logic        i_fifo_ready,
    // sensor samples and fifo levels
    input  wire logic        i_sample_valid,
    input  wire logic        i_sample_wakeup,
    input  wire logic        i_sample_zero_lat,
    input  wire logic        i_all_zero_lat,
    input  wire logic [15:0] i_wk_fill,
    input  wire logic [15:0] i_wk_size,
    input  wire logic [15:0] i_nw_fill,
    input  wire logic [15:0] i_nw_size,
    // per-sensor status bytes, sensor type t at index t-1
    input  wire logic [hub_pkg::SENSOR_COUNT-1:0][7:0] i_sensor_status
);
    typedef enum logic { MB_IDLE, MB_SERVE } mbox_state_type;

    typedef struct packed {
        logic [15:0]      ptr;      // patch load pointer
        logic [31:0]      crc;      // running checksum, not yet inverted
        logic             restart;  // restart register, reads back
        logic [63:0]      meta_nw;  // non-wakeup meta control
        logic [63:0]      meta_wk;  // wakeup meta control
        logic [15:0]      wm_wk;    // wakeup watermark
        logic [15:0]      wm_nw;    // non-wakeup watermark
        logic [7:0][7:0]  wbuf;     // staged write data
        logic [15:0][7:0] rbuf;     // parameter read data
        logic [7:0]       sel;      // latched selector
        logic [7:0]       ack;      // served selector
        mbox_state_type   mb;       // mailbox state
        logic             irq;      // host interrupt
        logic [7:0]       rdata;    // read answer
        logic             rvalid;   // read answer strobe
    } state_type;

    state_type   st_reg;
    state_type   st_next;
    patch_ram_if ram ();
    logic        buf_in_valid;
    logic        buf_in_ready;
    logic        evt_en;
    logic        evt_int;
    logic        wm_wk_hit;
    logic        wm_nw_hit;

    // one crc step per byte, reflected form
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] x;
        x = c ^ {24'h00_0000, d};
        for (int i = 0; i < 8; i++)
        begin
            x = x[0] ? ((x >> 1) ^ hub_pkg::CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction : crc_byte

    // clamp to size, zero disables
    function automatic logic wm_hit(input logic [15:0] wm, input logic [15:0] fill,
                                    input logic [15:0] size);
        logic [15:0] eff;
        eff = (wm > size) ? size : wm;
        return (wm != 16'h0000) && (fill >= eff);
    endfunction : wm_hit

    // patch memory
    patch_ram u_ram
    (
        .i_ref_clk (i_ref_clk),
        .bus       (ram.mem)
    );

    // output fifo staging, stalls events when full
    evt_buffer u_buf
    (
        .i_ref_clk   (i_ref_clk),
        .i_rst       (i_rst),
        .i_in_valid  (buf_in_valid),
        .i_in_data   ({2'b00, i_evt_wakeup, i_evt_index}),
        .o_in_ready  (buf_in_ready),
        .o_out_valid (o_fifo_valid),
        .o_out_data  (o_fifo_data),
        .i_out_ready (i_fifo_ready)
    );

    // memory write at the pointer while uploading
    assign ram.we    = i_reg_wr && (i_reg_addr == hub_pkg::BYTE_PORT) && i_upload_en;
    assign ram.addr  = st_reg.ptr;
    assign ram.wdata = i_reg_wdata;

    // event k: enable at bit 2k-1, interrupt at 2k-2
    assign evt_en       = i_evt_wakeup ? st_reg.meta_wk[{i_evt_index, 1'b1}]
                                       : st_reg.meta_nw[{i_evt_index, 1'b1}];
    assign evt_int      = i_evt_wakeup ? st_reg.meta_wk[{i_evt_index, 1'b0}]
                                       : st_reg.meta_nw[{i_evt_index, 1'b0}];
    assign buf_in_valid = i_evt_valid && evt_en;
    // disabled events drop at once, enabled ones wait
    assign o_evt_ready  = buf_in_ready || !evt_en;
    assign wm_wk_hit    = wm_hit(st_reg.wm_wk, i_wk_fill, i_wk_size);
    assign wm_nw_hit    = wm_hit(st_reg.wm_nw, i_nw_fill, i_nw_size);

    // outputs straight from state
    assign o_reg_rdata  = st_reg.rdata;
    assign o_reg_rvalid = st_reg.rvalid;
    assign o_core_reset = st_reg.restart;
    assign o_host_irq   = st_reg.irq;
    assign o_mbox_busy  = (st_reg.mb == MB_SERVE);

    // next-state logic
    always_comb
    begin
        st_next        = st_reg;
        st_next.rvalid = 1'b0;
        st_next.restart = 1'b0;
        // host writes
        if (i_reg_wr)
        begin
            unique case (i_reg_addr)
                hub_pkg::PTR_MSB_ADDR:
                begin
                    st_next.ptr[15:8] = i_reg_wdata;
                    st_next.crc       = hub_pkg::CRC_PRESET;
                end
                hub_pkg::PTR_LSB_ADDR:
                begin
                    st_next.ptr[7:0]  = i_reg_wdata;
                    st_next.crc       = hub_pkg::CRC_PRESET;
                end
                hub_pkg::BYTE_PORT:
                begin
                    // bytes outside upload mode are dropped
                    if (i_upload_en)
                    begin
                        st_next.ptr = st_reg.ptr + 16'h0001;
                        st_next.crc = crc_byte(st_reg.crc, i_reg_wdata);
                    end
                end
                hub_pkg::RESTART_ADDR:
                begin
                    st_next.restart = i_reg_wdata[0];
                end
                hub_pkg::IRQ_ACK_ADDR:
                begin
                    st_next.irq = 1'b0;
                end
                hub_pkg::PARAM_SEL:
                begin
                    // ignored while serving
                    if (st_reg.mb == MB_IDLE)
                    begin
                        st_next.sel = i_reg_wdata;
                        st_next.ack = 8'h00;
                        st_next.mb  = MB_SERVE;
                    end
                end
                default:
                begin
                    if ((i_reg_addr >= hub_pkg::WR_BUF_BASE) && (i_reg_addr <= hub_pkg::WR_BUF_LAST))
                    begin
                        st_next.wbuf[i_reg_addr[2:0] - hub_pkg::WR_BUF_BASE[2:0]] = i_reg_wdata;
                    end
                end
            endcase
        end
        // mailbox service, started by a selector write
        unique case (st_reg.mb)
            MB_IDLE:
            begin
            end
            MB_SERVE:
            begin
                if (st_reg.sel[hub_pkg::SEL_DIR_BIT])
                begin
                    // write; banks and reserved entries ignore it
                    unique case (st_reg.sel[6:0])
                        hub_pkg::PAR_META_NW: st_next.meta_nw = st_reg.wbuf;
                        hub_pkg::PAR_META_WK: st_next.meta_wk = st_reg.wbuf;
                        hub_pkg::PAR_FIFO:
                        begin
                            st_next.wm_wk = {st_reg.wbuf[1], st_reg.wbuf[0]};
                            st_next.wm_nw = {st_reg.wbuf[5], st_reg.wbuf[4]};
                        end
                        default: st_next.wm_wk = st_reg.wm_wk;
                    endcase
                end
                else
                begin
                    st_next.rbuf = '0;
                    if ((st_reg.sel[6:0] >= hub_pkg::PAR_BANK0) && (st_reg.sel[6:0] <= hub_pkg::PAR_BANK3))
                    begin
                        for (int n = 0; n < 16; n++)
                        begin
                            // byte n of bank b is sensor type 16b+n+1
                            st_next.rbuf[n] = i_sensor_status[{st_reg.sel[1:0] - 2'd3, 4'(n)}];
                        end
                    end
                    else
                    begin
                        unique case (st_reg.sel[6:0])
                            hub_pkg::PAR_META_NW: st_next.rbuf[7:0] = st_reg.meta_nw;
                            hub_pkg::PAR_META_WK: st_next.rbuf[7:0] = st_reg.meta_wk;
                            hub_pkg::PAR_FIFO:
                                st_next.rbuf[7:0] = {i_nw_size, st_reg.wm_nw, i_wk_size, st_reg.wm_wk};
                            default: st_next.rbuf = '0;
                        endcase
                    end
                end
                st_next.ack = st_reg.sel;
                st_next.mb  = MB_IDLE;
            end
        endcase
        // host reads, answer one edge later
        if (i_reg_rd)
        begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = 8'h00;
            if (i_reg_addr[7:4] == hub_pkg::RD_BUF_BASE[7:4])
            begin
                st_next.rdata = st_reg.rbuf[i_reg_addr[3:0]];
            end
            else if ((i_reg_addr >= hub_pkg::WR_BUF_BASE) && (i_reg_addr <= hub_pkg::WR_BUF_LAST))
            begin
                st_next.rdata = st_reg.wbuf[i_reg_addr[2:0] - hub_pkg::WR_BUF_BASE[2:0]];
            end
            else if ((i_reg_addr >= hub_pkg::CRC_B0_ADDR) && (i_reg_addr <= hub_pkg::CRC_B3_ADDR))
            begin
                // checksum shown inverted, low byte first
                st_next.rdata = 8'((~st_reg.crc) >> {i_reg_addr[1:0] - hub_pkg::CRC_B0_ADDR[1:0], 3'b000});
            end
            else
            begin
                unique case (i_reg_addr)
                    hub_pkg::PTR_MSB_ADDR: st_next.rdata = st_reg.ptr[15:8];
                    hub_pkg::PTR_LSB_ADDR: st_next.rdata = st_reg.ptr[7:0];
                    hub_pkg::BYTE_PORT:    st_next.rdata = ram.rdata;  // byte at the pointer
                    hub_pkg::RESTART_ADDR: st_next.rdata = {7'h00, st_reg.restart};
                    hub_pkg::PARAM_SEL:    st_next.rdata = st_reg.sel;
                    hub_pkg::PARAM_ACK:    st_next.rdata = st_reg.ack;
                    default:               st_next.rdata = 8'h00;
                endcase
            end
        end
        // interrupt sets last, so they beat an acknowledge
        if (buf_in_valid && buf_in_ready && evt_int && (i_evt_wakeup || !i_host_asleep_bit))
        begin
            st_next.irq = 1'b1;
        end
        if (i_all_zero_lat && !i_host_asleep_bit)
        begin
            // watermark ignored, every zero-latency sample interrupts
            if (i_sample_valid && i_sample_zero_lat)
            begin
                st_next.irq = 1'b1;
            end
        end
        else if (wm_wk_hit || (wm_nw_hit && !i_host_asleep_bit))
        begin
            st_next.irq = 1'b1;
        end
        else if (i_sample_valid && i_sample_zero_lat && i_sample_wakeup)
        begin
            st_next.irq = 1'b1;
        end
    end

    // state register
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            st_reg         <= '0;
            st_reg.ptr     <= hub_pkg::PTR_RESET;
            st_reg.crc     <= hub_pkg::CRC_PRESET;
            st_reg.meta_nw <= hub_pkg::META_RESET;
            st_reg.meta_wk <= hub_pkg::META_RESET;
            st_reg.wm_wk   <= hub_pkg::WM_RESET;
            st_reg.wm_nw   <= hub_pkg::WM_RESET;
            st_reg.mb      <= MB_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end
endmodule : hub_regs

/* hdl/patch_ram.sv */
// byte-wide patch memory with registered read data
`timescale 1ns/1ps
module patch_ram
(
    // clock
    input  wire logic  i_ref_clk,
    // access port
    patch_ram_if.mem   bus
);
    logic [7:0] mem_array [0:65535];  // full 16-bit address space

    // read data registered, one edge behind the address
    always_ff @(posedge i_ref_clk)
    begin
        if (bus.we)
        begin
            mem_array[bus.addr] <= bus.wdata;
        end
        bus.rdata <= mem_array[bus.addr];
    end
endmodule : patch_ram

/* hdl/patch_ram_if.sv */
// carrier between the register bank and the patch memory
`timescale 1ns/1ps
interface patch_ram_if;
    logic        we;     // write strobe
    logic [15:0] addr;   // byte address
    logic [7:0]  wdata;  // byte to store
    logic [7:0]  rdata;  // registered read data
    modport ctrl (output we, addr, wdata, input rdata);
    modport mem  (input we, addr, wdata, output rdata);
endinterface : patch_ram_if

/* verif/host_model.sv */
// host processor model issuing decoded register accesses
`timescale 1ns/1ps
module host_model
(
    // clock
    input  wire logic       i_clk,
    // register strobes toward the device
    output logic            o_wr,
    output logic            o_rd,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata,
    // read answer
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid
);
    logic [7:0] sent_q[$];  // bytes put on the byte port
    initial {o_wr, o_rd, o_addr, o_wdata} = '0;
    // one write, lines flipped after release
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk) #1 o_wr = 1;
        o_addr = a;
        o_wdata = d;
        @(posedge i_clk) #1 o_wr = 0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask : wr
    // one read; answer taken the cycle after
    task rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge i_clk) #1 o_rd = 1;
        o_addr = a;
        @(posedge i_clk) #1 o_rd = 0;
        o_addr = ~a;
        ok = i_rvalid;
        d = i_rdata;
    endtask : rd
    // patch upload from an image queue, 16-byte header skipped, byte order reversed in each 32-bit word
    task upload(input logic [7:0] img[$]);
        sent_q = {};
        wr(hub_pkg::PTR_MSB_ADDR, 8'h00);
        wr(hub_pkg::PTR_LSB_ADDR, 8'h00);
        for (int i = 16; i < img.size(); i++)
        begin
            sent_q.push_back(img[i ^ 3]);
            wr(hub_pkg::BYTE_PORT, img[i ^ 3]);
        end
    endtask : upload
endmodule : host_model

/* verif/hub_props.sv */
// concurrent checks on the hub register bank ports
`timescale 1ns/1ps
module hub_props
(
    // clock and reset
    input wire logic       i_ref_clk,
    input wire logic       i_rst,
    // host register bus
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       o_reg_rvalid,
    // controls and events
    input wire logic       o_core_reset,
    input wire logic       o_mbox_busy,
    input wire logic       o_host_irq,
    input wire logic       o_fifo_valid,
    input wire logic [7:0] o_fifo_data,
    input wire logic       i_fifo_ready,
    input wire logic       i_sample_valid,
    input wire logic       i_sample_zero_lat,
    input wire logic       i_all_zero_lat,
    input wire logic       i_host_asleep_bit
);
    // decoded host writes of interest
    wire rs_wr  = i_reg_wr && i_reg_addr == hub_pkg::RESTART_ADDR && i_reg_wdata[0];
    wire sel_wr = i_reg_wr && i_reg_addr == hub_pkg::PARAM_SEL;
    wire ack_wr = i_reg_wr && i_reg_addr == hub_pkg::IRQ_ACK_ADDR;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // high for exactly one cycle
    sequence s_one(logic s);
        s ##1 !s;
    endsequence
    a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
    a_no_spurious: assert property (!i_reg_rd |=> !o_reg_rvalid) else $error("answer without read");
    a_restart_pulse: assert property (rs_wr |=> s_one(o_core_reset)) else $error("restart pulse wrong");
    a_restart_cause: assert property (o_core_reset |-> $past(rs_wr)) else $error("restart uncaused");
    a_busy_pulse: assert property (sel_wr && !o_mbox_busy |=> s_one(o_mbox_busy)) else $error("busy wrong");
    a_busy_cause: assert property (o_mbox_busy |-> $past(sel_wr)) else $error("busy uncaused");
    a_fifo_hold: assert property (o_fifo_valid && !i_fifo_ready |=> o_fifo_valid && $stable(o_fifo_data))
        else $error("stalled head lost");
    a_irq_sticky: assert property (o_host_irq && !ack_wr |=> o_host_irq) else $error("irq dropped");
    a_zero_lat_irq: assert property (i_sample_valid && i_sample_zero_lat && i_all_zero_lat && !i_host_asleep_bit
        |=> o_host_irq) else $error("sample irq missing");
endmodule : hub_props
bind hub_regs hub_props props (.*);

/* verif/test_hub_regs.sv */
// self-checking bench of the hub register bank
`timescale 1ns/1ps
module test_hub_regs;
    // clock, reset and host bus
    logic             i_ref_clk = 0, i_rst = 1, i_reg_wr, i_reg_rd, o_reg_rvalid;
    logic [7:0]       i_reg_addr, i_reg_wdata, o_reg_rdata, o_fifo_data, d;
    // controls, events and samples
    logic             i_upload_en = 0, i_host_asleep_bit = 0, o_core_reset, o_host_irq, o_mbox_busy;
    logic             i_evt_valid = 0, i_evt_wakeup = 0, o_evt_ready, o_fifo_valid, i_fifo_ready = 0;
    logic [4:0]       i_evt_index = 0;
    logic             i_sample_valid = 0, i_sample_wakeup = 0, i_sample_zero_lat = 0, i_all_zero_lat = 0;
    logic [15:0]      i_wk_fill = 0, i_wk_size = 16'h0100, i_nw_fill = 0, i_nw_size = 16'h0040, wm;
    logic [63:0][7:0] i_sensor_status;
    // bench model and bookkeeping
    logic [7:0]       m_q[$], img[$], ev_q[$];
    logic [31:0]      crc;
    logic             ok;
    int               error_cnt = 0, cmp_count = 0, cycles = 0, seed = 32'h511d_c9ba;
    hub_regs dut (.*);
    host_model host (.i_clk(i_ref_clk), .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr),
                     .o_wdata(i_reg_wdata), .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid));
    always #10 i_ref_clk = ~i_ref_clk;
    // hang guard
    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            end_sim();
        end
    end
    task end_sim;
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // read and compare one byte
    task rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d, ok);
        chk("rvalid", 1, ok);
        chk("rdata", e, d);
    endtask : rchk
    // selector write, then one read that checks the echo
    task sel(input logic [7:0] s);
        host.wr(hub_pkg::PARAM_SEL, s);
        rchk(hub_pkg::PARAM_ACK, s);
    endtask : sel
    // stage m_q, write p, select it for reading
    task pwr(input logic [6:0] p);
        for (int i = 0; i < 8; i++) host.wr(hub_pkg::WR_BUF_BASE + 8'(i), m_q[i]);
        sel({1'b1, p});
        sel({1'b0, p});
    endtask : pwr
    task pcmp(input int n);
        for (int i = 0; i < n; i++) rchk(hub_pkg::RD_BUF_BASE + 8'(i), m_q[i]);
    endtask : pcmp
    // offer one meta event until taken
    task evt(input logic [4:0] x);
        @(posedge i_ref_clk) #1 i_evt_valid = 1;
        i_evt_index = x;
        do @(negedge i_ref_clk); while (o_evt_ready !== 1'b1);
        @(posedge i_ref_clk) #1 i_evt_valid = 0;
        i_evt_index = ~x;
    endtask : evt
    function automatic logic [31:0] crc_b(logic [31:0] c, logic [7:0] b);
        c ^= 32'(b);
        for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ hub_pkg::CRC_POLY : c >> 1;
        return c;
    endfunction : crc_b
    initial
    begin
        for (int t = 0; t < 64; t++) i_sensor_status[t] = 8'($random(seed));
        repeat (3) @(posedge i_ref_clk);
        #1 i_rst = 0;
        rchk(hub_pkg::PTR_MSB_ADDR, 8'h00);
        rchk(hub_pkg::PTR_LSB_ADDR, 8'h00);
        rchk(hub_pkg::CRC_B0_ADDR, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 24; i++) img.push_back(8'($random(seed)));
        i_upload_en = 1;
        host.upload(img);
        crc = hub_pkg::CRC_PRESET;
        foreach (host.sent_q[i]) crc = crc_b(crc, host.sent_q[i]);
        for (int k = 0; k < 4; k++) rchk(hub_pkg::CRC_B0_ADDR + 8'(k), ~crc[8*k +: 8]);
        i_upload_en = 0;
        host.wr(hub_pkg::BYTE_PORT, 8'h5A);
        rchk(hub_pkg::PTR_LSB_ADDR, 8'h08);
        host.wr(hub_pkg::PTR_LSB_ADDR, 8'h00);
        rchk(hub_pkg::BYTE_PORT, host.sent_q[0]);
        rchk(hub_pkg::CRC_B3_ADDR, 8'h00);
        host.wr(hub_pkg::PTR_MSB_ADDR, 8'h12);
        rchk(hub_pkg::PTR_MSB_ADDR, 8'h12);
        rchk(hub_pkg::PTR_LSB_ADDR, 8'h00);
        $display("test upload done");
        host.wr(hub_pkg::RESTART_ADDR, 8'h01);
        chk("core_reset", 1, o_core_reset);
        @(posedge i_ref_clk) #1 chk("core_reset", 0, o_core_reset);
        rchk(hub_pkg::RESTART_ADDR, 8'h00);
        $display("test restart done");
        wm = 16'($random(seed));
        m_q = '{wm[7:0], wm[15:8], 8'h11, 8'h22, 8'hFF, 8'hFF, 8'h33, 8'h44};
        pwr(hub_pkg::PAR_FIFO);
        m_q = '{wm[7:0], wm[15:8], i_wk_size[7:0], i_wk_size[15:8],
                8'hFF, 8'hFF, i_nw_size[7:0], i_nw_size[15:8]};
        pcmp(8);
        for (int b = 0; b < 4; b++)
        begin
            sel({1'b0, hub_pkg::PAR_BANK0 + 7'(b)});
            m_q = {};
            for (int n = 0; n < 16; n++) m_q.push_back(i_sensor_status[16*b+n]);
            pcmp(16);
        end
        m_q = '{8'h0B, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hAA};
        pwr(hub_pkg::PAR_META_NW);
        pcmp(8);
        $display("test mailbox done");
        host.wr(hub_pkg::IRQ_ACK_ADDR, 8'h00);
        ev_q = '{8'h01, 8'h00};
        evt(5'h01);
        evt(5'h02);
        chk("irq", 0, o_host_irq);
        evt(5'h00);
        @(posedge i_ref_clk) #1 chk("irq", 1, o_host_irq);
        @(posedge i_ref_clk) #1 chk("evt_ready", 0, o_evt_ready);
        i_fifo_ready = 1;
        foreach (ev_q[k])
        begin
            chk("fifo_valid", 1, o_fifo_valid);
            chk("fifo_data", ev_q[k], o_fifo_data);
            @(posedge i_ref_clk) #1;
        end
        chk("fifo_valid", 0, o_fifo_valid);
        $display("test events done");
        host.wr(hub_pkg::IRQ_ACK_ADDR, 8'h00);
        i_nw_fill = 16'h003F;
        repeat (3) @(posedge i_ref_clk);
        chk("irq", 0, o_host_irq);
        #1 i_nw_fill = 16'h0040;
        repeat (3) @(posedge i_ref_clk);
        chk("irq", 1, o_host_irq);
        #1 i_host_asleep_bit = 1;
        host.wr(hub_pkg::IRQ_ACK_ADDR, 8'h00);
        repeat (3) @(posedge i_ref_clk);
        chk("irq", 0, o_host_irq);
        #1 i_host_asleep_bit = 0;
        i_nw_fill = 16'h0000;
        i_all_zero_lat = 1;
        host.wr(hub_pkg::IRQ_ACK_ADDR, 8'h00);
        i_sample_valid = 1;
        i_sample_zero_lat = 1;
        @(posedge i_ref_clk) #1 i_sample_valid = 0;
        @(posedge i_ref_clk) #1 chk("irq", 1, o_host_irq);
        $display("test interrupt done");
        end_sim();
    end
endmodule : test_hub_regs
